// file: hw/sys_vectors_regs.vh
// register map, vector codes and event positions of the reset and nmi vector block
// What this block does
// - Three vector registers; each reads zero when its group has nothing pending.
// - Reset-cause vector at 019Eh; brownout is 02h and highest; 32h-3Eh reserved.
// - Reset-pin brownout reports 04h; software brownout sits one position lower.
// - Deep-sleep wakeup 08h, security violation 0Ah, high supply event 0Eh; 0Ch reserved.
// - Software power-on request reports 14h; 10h and 12h stay reserved.
// - Watchdog time-out reports 16h, watchdog password violation 18h.
// - Nvm password 1Ah, uncorrectable nvm error 1Ch, peripheral area fetch 1Eh.
// - Power management password 20h, protection unit 22h, clock system 24h.
// - Segment violations set to reset: ip 26h, info 28h, segments 1-3 to 2Eh.
// - Access time error (wait states too few) reports 30h.
// - System nmi vector at 019Ch; uncorrectable nvm error 04h; 02h, 06h reserved.
// - Segment nmi violations: ip 08h, info 0Ah, segment 1 0Ch, segment 3 10h.
// - Vacant memory access reports system nmi code 12h.
// - Mailbox incoming data reports 14h, outgoing buffer event 16h.
// - Correctable nvm error reports 18h; codes up to 1Eh reserved.
// - User nmi vector at 019Ah; nmi pin 02h highest, oscillator fault 04h.
// - Debug-port mailbox exchanges words between application and debug tool.
`ifndef SYS_VECTORS_REGS_VH
`define SYS_VECTORS_REGS_VH

// register byte addresses
`define ADDR_USER_NMI_VECTOR   16'h019A
`define ADDR_SYSTEM_NMI_VECTOR 16'h019C
`define ADDR_RESET_CAUSE_VECTOR 16'h019E
`define ADDR_MAILBOX_IN        16'h0190
`define ADDR_MAILBOX_OUT       16'h0192
`define ADDR_MAILBOX_STATUS    16'h0194

// widths and group sizes
`define REG_W                  16
`define RC_N                   24
`define SN_N                   12
`define UN_N                   2
`define ZERO16                 16'h0000

// reset-cause positions; code = 2 * (position + 1)
`define RC_BROWNOUT            0
`define RC_RESET_PIN           1
`define RC_SW_BROWNOUT         2
`define RC_SLEEP_WAKE          3
`define RC_SECURITY            4
`define RC_HIGH_SUPPLY         6
`define RC_SW_POWERON          9
`define RC_WDT_TIMEOUT         10
`define RC_WDT_PASSWORD        11
`define RC_NVM_PASSWORD        12
`define RC_NVM_UNCORR          13
`define RC_PERIPH_FETCH        14
`define RC_PMM_PASSWORD        15
`define RC_MPU_PASSWORD        16
`define RC_CS_PASSWORD         17
`define RC_SEG_BASE            18
`define RC_ACCESS_TIME         23

// system nmi positions
`define SN_NVM_UNCORR          1
`define SN_SEG_BASE            3
`define SN_VACANT              8
`define SN_MBOX_IN             9
`define SN_MBOX_OUT            10
`define SN_NVM_CORR            11

// user nmi positions
`define UN_NMI_PIN             0
`define UN_OSC_FAULT           1

// mailbox status bits
`define MB_IN_FULL             0
`define MB_OUT_FULL            1

`endif

// file: hw/priority_vector.v
// priority encoder turning a pending-flag set into an even vector code
`timescale 1ns/1ns
module priority_vector #(
    parameter N = 12
) (
    // pending flags, position 0 is highest priority
    input  wire [N-1:0] pend,
    // resulting code and the flag it names
    output reg  [15:0]  code,
    output reg  [N-1:0] hit
);
    integer i;
    always @* begin
        code = 16'h0000;
        hit  = {N{1'b0}};
        // walk from lowest priority up so the highest pending wins
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (pend[i]) begin
                code = {i[14:0] + 15'h0001, 1'b0};
                hit  = {N{1'b0}};
                hit[i] = 1'b1;
            end
        end
    end
endmodule

// file: hw/system_reset_nmi_vectors.v
// reset-cause, system nmi and user nmi vector generators with debug mailbox
`timescale 1ns/1ns
`include "sys_vectors_regs.vh"
module system_reset_nmi_vectors (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // peripheral bus
    input  wire [15:0] per_addr,
    input  wire        per_rd,
    input  wire        per_wr,
    input  wire [15:0] per_wdata,
    output reg  [15:0] per_rdata_q,
    // brownout-class reset events
    input  wire        reset_pin_flag,
    input  wire        software_brownout_request,
    input  wire        deepest_sleep_mode,
    input  wire        security_violation,
    input  wire        high_supply_supervisor_flag,
    // power-on and power-up-clear reset events
    input  wire        software_poweron_request,
    input  wire        watchdog_timeout_flag,
    input  wire        watchdog_password,
    input  wire        nvm_controller_password,
    input  wire        peripheral_fetch,
    input  wire        power_mgmt_password,
    input  wire        protection_unit_password,
    input  wire        clock_system_password,
    input  wire        access_time_error_flag,
    // nonvolatile memory errors; only the uncorrectable one is routed by nvm_error_resets
    input  wire        nvm_uncorrectable,
    input  wire        nvm_correctable,
    input  wire        nvm_error_resets,
    // protection segment violations, routed by segment_resets
    input  wire        ip_segment_violation_flag,
    input  wire        info_segment_violation_flag,
    input  wire        segment_one_violation_flag,
    input  wire        segment_two_violation_flag,
    input  wire        segment_three_violation_flag,
    input  wire [4:0]  segment_resets,
    // other system nmi events
    input  wire        vacant_access_flag,
    // user nmi sources
    input  wire        nmi_pin,
    input  wire        oscillator_fault_flag,
    // debug-port side of the mailbox
    input  wire        dbg_in_wr,
    input  wire [15:0] dbg_in_data,
    input  wire        dbg_out_rd,
    output reg  [15:0] dbg_out_data_q,
    output reg         dbg_in_full_q,
    output reg         dbg_out_full_q
);

    // event flags
    reg  [`RC_N-1:0] rc_flag_q;
    reg  [`RC_N-1:0] rc_flag_d;
    reg  [`SN_N-1:0] sn_flag_q;
    reg  [`SN_N-1:0] sn_flag_d;
    reg  [`UN_N-1:0] un_flag_q;
    reg  [`UN_N-1:0] un_flag_d;

    // set and clear terms
    reg  [`RC_N-1:0] rc_set;
    reg  [`SN_N-1:0] sn_set;
    reg  [`UN_N-1:0] un_set;
    wire [`RC_N-1:0] rc_hit;
    wire [`SN_N-1:0] sn_hit;
    wire [`UN_N-1:0] un_hit;
    wire [15:0]      rc_code;
    wire [15:0]      sn_code;
    wire [15:0]      un_code;

    // nmi pin synchroniser and edge detect
    reg              nmi_meta_q;
    reg              nmi_sync_q;
    reg              nmi_prev_q;

    // mailbox storage
    reg  [15:0]      mb_in_data_q;
    reg              mb_out_drained;

    // bus decode
    wire             rd_rc;
    wire             rd_sn;
    wire             rd_un;
    wire             rd_mb_in;
    wire             rd_mb_st;
    wire             wr_mb_out;
    wire             mb_in_take;
    reg  [15:0]      rdata_d;

    assign rd_rc     = per_rd && (per_addr == `ADDR_RESET_CAUSE_VECTOR);
    assign rd_sn     = per_rd && (per_addr == `ADDR_SYSTEM_NMI_VECTOR);
    assign rd_un     = per_rd && (per_addr == `ADDR_USER_NMI_VECTOR);
    assign rd_mb_in  = per_rd && (per_addr == `ADDR_MAILBOX_IN);
    assign rd_mb_st  = per_rd && (per_addr == `ADDR_MAILBOX_STATUS);
    // writes to the three vector addresses decode to nothing at all
    assign wr_mb_out = per_wr && (per_addr == `ADDR_MAILBOX_OUT);
    assign mb_in_take = rd_mb_in && dbg_in_full_q;

    // priority encoders; position zero is the highest priority
    priority_vector #(
        .N    (`RC_N)
    ) u_rc_prio (
        .pend (rc_flag_q),
        .code (rc_code),
        .hit  (rc_hit)
    );

    priority_vector #(
        .N    (`SN_N)
    ) u_sn_prio (
        .pend (sn_flag_q),
        .code (sn_code),
        .hit  (sn_hit)
    );

    priority_vector #(
        .N    (`UN_N)
    ) u_un_prio (
        .pend (un_flag_q),
        .code (un_code),
        .hit  (un_hit)
    );

    // reset-cause event mapping; unlisted positions 5, 7 and 8 stay zero as reserved codes; position 0 is set only by reset
    always @* begin
        rc_set = {`RC_N{1'b0}};
        rc_set[`RC_RESET_PIN]    = reset_pin_flag;
        rc_set[`RC_SW_BROWNOUT]  = software_brownout_request;
        rc_set[`RC_SLEEP_WAKE]   = deepest_sleep_mode;
        rc_set[`RC_SECURITY]     = security_violation;
        rc_set[`RC_HIGH_SUPPLY]  = high_supply_supervisor_flag;
        rc_set[`RC_SW_POWERON]   = software_poweron_request;
        rc_set[`RC_WDT_TIMEOUT]  = watchdog_timeout_flag;
        rc_set[`RC_WDT_PASSWORD] = watchdog_password;
        rc_set[`RC_NVM_PASSWORD] = nvm_controller_password;
        rc_set[`RC_NVM_UNCORR]   = nvm_uncorrectable && nvm_error_resets;
        rc_set[`RC_PERIPH_FETCH] = peripheral_fetch;
        rc_set[`RC_PMM_PASSWORD] = power_mgmt_password;
        rc_set[`RC_MPU_PASSWORD] = protection_unit_password;
        rc_set[`RC_CS_PASSWORD]  = clock_system_password;
        // segments ip, info, 1, 2, 3 occupy consecutive positions
        rc_set[`RC_SEG_BASE+0]   = ip_segment_violation_flag && segment_resets[0];
        rc_set[`RC_SEG_BASE+1]   = info_segment_violation_flag && segment_resets[1];
        rc_set[`RC_SEG_BASE+2]   = segment_one_violation_flag && segment_resets[2];
        rc_set[`RC_SEG_BASE+3]   = segment_two_violation_flag && segment_resets[3];
        rc_set[`RC_SEG_BASE+4]   = segment_three_violation_flag && segment_resets[4];
        rc_set[`RC_ACCESS_TIME]  = access_time_error_flag;
    end

    // system nmi event mapping; positions 0 and 2 are reserved
    always @* begin
        sn_set = {`SN_N{1'b0}};
        sn_set[`SN_NVM_UNCORR] = nvm_uncorrectable && !nvm_error_resets;
        // a violation set to reset is not also reported as an nmi
        sn_set[`SN_SEG_BASE+0] = ip_segment_violation_flag && !segment_resets[0];
        sn_set[`SN_SEG_BASE+1] = info_segment_violation_flag && !segment_resets[1];
        sn_set[`SN_SEG_BASE+2] = segment_one_violation_flag && !segment_resets[2];
        sn_set[`SN_SEG_BASE+3] = segment_two_violation_flag && !segment_resets[3];
        sn_set[`SN_SEG_BASE+4] = segment_three_violation_flag && !segment_resets[4];
        sn_set[`SN_VACANT]     = vacant_access_flag;
        sn_set[`SN_MBOX_IN]    = dbg_in_wr;
        sn_set[`SN_MBOX_OUT]   = mb_out_drained;
        sn_set[`SN_NVM_CORR]   = nvm_correctable;
    end

    // user nmi event mapping
    always @* begin
        un_set = {`UN_N{1'b0}};
        un_set[`UN_NMI_PIN]   = nmi_sync_q && !nmi_prev_q;
        // a fault still present re-raises the flag after it is read
        un_set[`UN_OSC_FAULT] = oscillator_fault_flag;
    end

    // a read clears only the flag it reported; a same-cycle set wins
    always @* begin
        rc_flag_d = (rc_flag_q & ~(rd_rc ? rc_hit : {`RC_N{1'b0}})) | rc_set;
        sn_flag_d = (sn_flag_q & ~(rd_sn ? sn_hit : {`SN_N{1'b0}})) | sn_set;
        un_flag_d = (un_flag_q & ~(rd_un ? un_hit : {`UN_N{1'b0}})) | un_set;
    end

    // reset is itself a brownout, so that flag comes up set
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rc_flag_q <= {{(`RC_N-1){1'b0}}, 1'b1};
            sn_flag_q <= {`SN_N{1'b0}};
            un_flag_q <= {`UN_N{1'b0}};
        end else begin
            rc_flag_q <= rc_flag_d;
            sn_flag_q <= sn_flag_d;
            un_flag_q <= un_flag_d;
        end
    end

    // nmi pin is asynchronous; the edge is taken from the second and third stages
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nmi_meta_q <= 1'b0;
            nmi_sync_q <= 1'b0;
            nmi_prev_q <= 1'b0;
        end else begin
            nmi_meta_q <= nmi_pin;
            nmi_sync_q <= nmi_meta_q;
            nmi_prev_q <= nmi_sync_q;
        end
    end

    // incoming mailbox word; a new debug write overwrites an unread word
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mb_in_data_q  <= `ZERO16;
            dbg_in_full_q <= 1'b0;
        end else begin
            if (dbg_in_wr) begin
                mb_in_data_q  <= dbg_in_data;
                dbg_in_full_q <= 1'b1;
            end else if (mb_in_take) begin
                dbg_in_full_q <= 1'b0;
            end
        end
    end

    // outgoing mailbox word; drained by the debug tool
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dbg_out_data_q <= `ZERO16;
            dbg_out_full_q <= 1'b0;
            mb_out_drained <= 1'b0;
        end else begin
            mb_out_drained <= dbg_out_rd && dbg_out_full_q && !wr_mb_out;
            if (wr_mb_out) begin
                dbg_out_data_q <= per_wdata;
                dbg_out_full_q <= 1'b1;
            end else if (dbg_out_rd) begin
                dbg_out_full_q <= 1'b0;
            end
        end
    end

    // read mux; unmapped or idle reads return zero
    always @* begin
        rdata_d = `ZERO16;
        if (rd_rc) begin
            rdata_d = rc_code;
        end else if (rd_sn) begin
            rdata_d = sn_code;
        end else if (rd_un) begin
            rdata_d = un_code;
        end else if (rd_mb_in) begin
            rdata_d = mb_in_data_q;
        end else if (rd_mb_st) begin
            rdata_d = `ZERO16;
            rdata_d[`MB_IN_FULL]  = dbg_in_full_q;
            rdata_d[`MB_OUT_FULL] = dbg_out_full_q;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            per_rdata_q <= `ZERO16;
        end else begin
            per_rdata_q <= rdata_d;
        end
    end

endmodule

// file: tb/sys_vectors_props.sv
// concurrent checks on the ports of the reset and nmi vector block
`timescale 1ns/1ns
`include "sys_vectors_regs.vh"
module sys_vectors_props (
    // clock and reset
    input wire        sys_clk,
    input wire        rst,
    // peripheral bus
    input wire [15:0] per_addr,
    input wire        per_rd,
    input wire        per_wr,
    input wire [15:0] per_wdata,
    input wire [15:0] per_rdata_q,
    // user source and mailbox
    input wire        oscillator_fault_flag,
    input wire        dbg_in_wr,
    input wire [15:0] dbg_in_data,
    input wire        dbg_out_rd,
    input wire [15:0] dbg_out_data_q,
    input wire        dbg_out_full_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire rd_rc    = per_rd && per_addr == `ADDR_RESET_CAUSE_VECTOR;
    wire rd_sn    = per_rd && per_addr == `ADDR_SYSTEM_NMI_VECTOR;
    wire rd_un    = per_rd && per_addr == `ADDR_USER_NMI_VECTOR;
    wire cpu_fill = per_wr && per_addr == `ADDR_MAILBOX_OUT;
    wire mapped   = rd_rc || rd_sn || rd_un || (per_addr inside
                    {`ADDR_MAILBOX_IN, `ADDR_MAILBOX_OUT, `ADDR_MAILBOX_STATUS});
    // the incoming word must survive the cycle in which the tool drops its strobe
    sequence s_in_then_read;
        dbg_in_wr ##1 !dbg_in_wr ##1 (per_rd && per_addr == `ADDR_MAILBOX_IN && !dbg_in_wr);
    endsequence
    sequence s_first_read;
        $fell(rst) ##1 rd_rc;
    endsequence
    chk_idle_read_zero: assert property (!per_rd |=> per_rdata_q == 16'h0000)
        else $error("read data not zero after an idle cycle");
    chk_rc_code_set: assert property (rd_rc |=> per_rdata_q[0] == 1'b0 &&
        per_rdata_q <= 16'h0030 && !(per_rdata_q inside {16'h000c, 16'h0010, 16'h0012}))
        else $error("reset cause code outside the defined set");
    chk_sn_code_set: assert property (rd_sn |=> per_rdata_q[0] == 1'b0 &&
        per_rdata_q <= 16'h0018 && !(per_rdata_q inside {16'h0002, 16'h0006}))
        else $error("system nmi code outside the defined set");
    chk_un_code_set: assert property (rd_un |=> per_rdata_q inside
        {16'h0000, 16'h0002, 16'h0004})
        else $error("user nmi code outside the defined set");
    chk_osc_level: assert property (oscillator_fault_flag [*2] ##0 rd_un
        |=> per_rdata_q inside {16'h0002, 16'h0004})
        else $error("oscillator fault held but user nmi reads zero");
    chk_unmapped_zero: assert property (per_rd && !mapped |=> per_rdata_q == 16'h0000)
        else $error("unmapped read returned data");
    chk_first_brownout: assert property (s_first_read |=> per_rdata_q == 16'h0002)
        else $error("first reset cause read after reset is not brownout");
    chk_mbox_in_data: assert property (s_in_then_read
        |=> per_rdata_q == $past(dbg_in_data, 3))
        else $error("mailbox input word not returned to the cpu");
    chk_mbox_out_fill: assert property (cpu_fill
        |=> dbg_out_full_q && dbg_out_data_q == $past(per_wdata))
        else $error("cpu mailbox write not presented to the tool");
    chk_mbox_out_take: assert property (dbg_out_rd && dbg_out_full_q && !cpu_fill
        |=> !dbg_out_full_q)
        else $error("outgoing word still full after the tool took it");
endmodule

// file: tb/dbg_tool.sv
// debug tool model on the far side of the mailbox
`timescale 1ns/1ns
module dbg_tool (
    // clock
    input  wire         sys_clk,
    // mailbox pins
    output logic        dbg_in_wr,
    output logic [15:0] dbg_in_data,
    output logic        dbg_out_rd,
    input  wire  [15:0] dbg_out_data_q,
    input  wire         dbg_out_full_q
);
    initial begin
        dbg_in_wr = 1'b0;
        dbg_in_data = 16'h0000;
        dbg_out_rd = 1'b0;
    end
    task automatic send(input logic [15:0] w);
        @(negedge sys_clk);
        dbg_in_wr = 1'b1;
        dbg_in_data = w;
        @(negedge sys_clk);
        dbg_in_wr = 1'b0;
        // a released data line shows the inverse so a stale word cannot pass
        dbg_in_data = ~w;
    endtask
    task automatic take(output logic [15:0] w, input int slow);
        int n;
        n = 0;
        repeat (slow) @(negedge sys_clk);
        while (dbg_out_full_q !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        dbg_out_rd = 1'b1;
        @(posedge sys_clk);
        w = dbg_out_data_q;
        @(negedge sys_clk);
        dbg_out_rd = 1'b0;
    endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the reset and nmi vector block
`timescale 1ns/1ns
`include "sys_vectors_regs.vh"
module tb;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] per_addr = 16'h0000;
    logic        per_rd = 1'b0;
    logic        per_wr = 1'b0;
    logic [15:0] per_wdata = 16'h0000;
    logic [21:0] ev = 22'h00_0000;
    logic        nvm_error_resets = 1'b0;
    logic [4:0]  segment_resets = 5'h00;
    logic        nmi_pin = 1'b0;
    logic        oscillator_fault_flag = 1'b0;
    wire  [15:0] per_rdata_q;
    wire  [15:0] dbg_in_data;
    wire  [15:0] dbg_out_data_q;
    wire         dbg_in_wr;
    wire         dbg_out_rd;
    wire         dbg_in_full_q;
    wire         dbg_out_full_q;
    logic [15:0] expq[$];
    logic        rd_seen = 1'b0;
    logic [31:0] seed = 32'h0000_f1ab;
    logic [15:0] w;
    logic [15:0] a;
    logic [15:0] c;
    int          n_mismatch = 0;
    int          comparisons = 0;
    localparam logic [13:0][7:0] rc_code = {8'h30, 8'h24, 8'h22, 8'h20, 8'h1e, 8'h1a,
        8'h18, 8'h16, 8'h14, 8'h0e, 8'h0a, 8'h08, 8'h06, 8'h04};
    localparam logic [15:0] rc = `ADDR_RESET_CAUSE_VECTOR;
    localparam logic [15:0] sn = `ADDR_SYSTEM_NMI_VECTOR;
    localparam logic [15:0] un = `ADDR_USER_NMI_VECTOR;
    always #5 sys_clk = ~sys_clk;
    system_reset_nmi_vectors u_system_reset_nmi_vectors (
        .sys_clk, .rst, .per_addr, .per_rd, .per_wr, .per_wdata, .per_rdata_q,
        .reset_pin_flag(ev[0]), .software_brownout_request(ev[1]), .deepest_sleep_mode(ev[2]),
        .security_violation(ev[3]), .high_supply_supervisor_flag(ev[4]),
        .software_poweron_request(ev[5]), .watchdog_timeout_flag(ev[6]),
        .watchdog_password(ev[7]), .nvm_controller_password(ev[8]), .peripheral_fetch(ev[9]),
        .power_mgmt_password(ev[10]), .protection_unit_password(ev[11]),
        .clock_system_password(ev[12]), .access_time_error_flag(ev[13]),
        .nvm_uncorrectable(ev[14]), .nvm_correctable(ev[15]), .nvm_error_resets,
        .ip_segment_violation_flag(ev[16]), .info_segment_violation_flag(ev[17]),
        .segment_one_violation_flag(ev[18]), .segment_two_violation_flag(ev[19]),
        .segment_three_violation_flag(ev[20]), .segment_resets, .vacant_access_flag(ev[21]),
        .nmi_pin, .oscillator_fault_flag, .dbg_in_wr, .dbg_in_data, .dbg_out_rd,
        .dbg_out_data_q, .dbg_in_full_q, .dbg_out_full_q);
    dbg_tool u_dbg_tool (.sys_clk, .dbg_in_wr, .dbg_in_data, .dbg_out_rd, .dbg_out_data_q,
        .dbg_out_full_q);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [15:0] ad, input logic [15:0] exp);
        @(negedge sys_clk);
        per_rd = 1'b1;
        per_addr = ad;
        expq.push_back(exp);
        @(negedge sys_clk);
        per_rd = 1'b0;
    endtask
    task automatic wr(input logic [15:0] ad, input logic [15:0] d);
        @(negedge sys_clk);
        per_wr = 1'b1;
        per_addr = ad;
        per_wdata = d;
        @(negedge sys_clk);
        per_wr = 1'b0;
    endtask
    task automatic pulse(input logic [21:0] m);
        @(negedge sys_clk);
        ev = m;
        @(negedge sys_clk);
        ev = 22'h00_0000;
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // read data is registered, so the note is compared one cycle after the strobe
    always @(posedge sys_clk) rd_seen <= per_rd;
    always @(negedge sys_clk) begin
        if (rd_seen && expq.size() > 0) begin
            check("per_rdata_q", per_rdata_q, expq.pop_front());
        end
    end
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        rd(rc, 16'h0002);
        rd(rc, 16'h0000);
        for (int i = 0; i < 14; i++) begin
            pulse(22'h00_0001 << i);
            rd(rc, {8'h00, rc_code[i]});
            rd(rc, 16'h0000);
        end
        for (int r = 1; r >= 0; r--) begin
            nvm_error_resets = (r == 1);
            segment_resets = (r == 1) ? 5'h1f : 5'h00;
            for (int i = 0; i < 6; i++) begin
                pulse(i == 0 ? 22'h00_4000 : 22'h00_8000 << i);
                a = (r == 1) ? rc : sn;
                c = (r == 1) ? 16'h0024 + 16'(2 * i) : 16'h0006 + 16'(2 * i);
                if (i == 0) c = (r == 1) ? 16'h001c : 16'h0004;
                rd(a, c);
                rd(a ^ 16'h0002, 16'h0000);
                rd(a, 16'h0000);
            end
        end
        pulse(22'h00_2001);
        rd(rc, 16'h0004);
        rd(rc, 16'h0030);
        pulse(22'h20_8000);
        rd(sn, 16'h0012);
        rd(sn, 16'h0018);
        rd(sn, 16'h0000);
        pulse(22'h00_0040);
        seed = lfsr(seed);
        wr(rc, seed[15:0]);
        wr(16'h0100, seed[31:16]);
        rd(rc, 16'h0016);
        rd(16'h0100, 16'h0000);
        oscillator_fault_flag = 1'b1;
        nmi_pin = 1'b1;
        repeat (4) @(negedge sys_clk);
        rd(un, 16'h0002);
        rd(un, 16'h0004);
        rd(un, 16'h0004);
        oscillator_fault_flag = 1'b0;
        rd(un, 16'h0004);
        rd(un, 16'h0000);
        nmi_pin = 1'b0;
        seed = lfsr(seed);
        u_dbg_tool.send(seed[15:0]);
        check("dbg_in_full_q", {15'h0000, dbg_in_full_q}, 16'h0001);
        rd(`ADDR_MAILBOX_IN, seed[15:0]);
        check("dbg_in_full_q", {15'h0000, dbg_in_full_q}, 16'h0000);
        rd(sn, 16'h0014);
        seed = lfsr(seed);
        wr(`ADDR_MAILBOX_OUT, seed[15:0]);
        rd(`ADDR_MAILBOX_STATUS, 16'h0002);
        u_dbg_tool.take(w, 3);
        check("dbg_out_data_q", w, seed[15:0]);
        rd(sn, 16'h0016);
        rd(sn, 16'h0000);
        pulse(22'h00_0040);
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        rd(rc, 16'h0002);
        rd(rc, 16'h0000);
        repeat (2) @(negedge sys_clk);
        check("unanswered reads", 16'(expq.size()), 16'h0000);
        tally_and_finish();
    end
endmodule
bind system_reset_nmi_vectors sys_vectors_props u_sys_vectors_props (
    .sys_clk, .rst, .per_addr, .per_rd, .per_wr, .per_wdata, .per_rdata_q,
    .oscillator_fault_flag, .dbg_in_wr, .dbg_in_data, .dbg_out_rd, .dbg_out_data_q,
    .dbg_out_full_q);
